// ---- msc_pkg.sv ----
/*
  constants for the metering sample correction block: register offsets,
  control bit positions, reset values and fixed-point scaling.
  assumes a 16-bit host register port and 16-bit signed converter samples.
*/
package msc_pkg;
  // register offsets (word index on the plain register port)
  localparam logic [4:0] MSC_CTRL_OFS = 5'h00;
  localparam logic [4:0] MSC_SPIKE_LIM_OFS = 5'h01;
  localparam logic [4:0] MSC_CM_COMP_OFS = 5'h02;
  localparam logic [4:0] MSC_V_OFS_OFS = 5'h03;
  localparam logic [4:0] MSC_I1_OFS_OFS = 5'h04;
  localparam logic [4:0] MSC_I2_OFS_OFS = 5'h05;
  localparam logic [4:0] MSC_I1_SCALE_OFS = 5'h06;
  localparam logic [4:0] MSC_I2_SCALE_OFS = 5'h07;
  localparam logic [4:0] MSC_I1_GAIN_OFS = 5'h08;
  localparam logic [4:0] MSC_I2_GAIN_OFS = 5'h09;
  localparam logic [4:0] MSC_I1_PHASE_OFS = 5'h0a;
  localparam logic [4:0] MSC_I2_PHASE_OFS = 5'h0b;
  localparam logic [4:0] MSC_P1_OFS_LO_OFS = 5'h0c;
  localparam logic [4:0] MSC_P1_OFS_HI_OFS = 5'h0d;
  localparam logic [4:0] MSC_P2_OFS_LO_OFS = 5'h0e;
  localparam logic [4:0] MSC_P2_OFS_HI_OFS = 5'h0f;
  localparam logic [4:0] MSC_FLAG_OFS = 5'h10;
  localparam logic [4:0] MSC_MSG_EN_OFS = 5'h11;
  localparam logic [4:0] MSC_IRQ_STAT_OFS = 5'h12;
  localparam logic [4:0] MSC_IRQ_MASK_OFS = 5'h13;
  localparam logic [4:0] MSC_V_OUT_OFS = 5'h14;
  localparam logic [4:0] MSC_I1_OUT_OFS = 5'h15;
  localparam logic [4:0] MSC_I2_OUT_OFS = 5'h16;
  // control word bit positions
  localparam int MSC_V_DC_BIT = 5;
  localparam int MSC_I1_DC_BIT = 6;
  localparam int MSC_I2_DC_BIT = 7;
  localparam int MSC_SPIKE_BIT = 8;
  localparam int MSC_CMR_BIT = 9;
  // interrupt status bits
  localparam int MSC_IRQ_SAMPLE_BIT = 0;
  localparam int MSC_IRQ_SPIKE_BIT = 1;
  localparam int MSC_IRQ_MSG_BIT = 2;
  // reset values
  localparam logic [15:0] MSC_CTRL_RST = 16'h0000;
  localparam logic [15:0] MSC_ZERO_RST = 16'h0000;
  localparam logic [15:0] MSC_UNITY_RST = 16'h4000;
  localparam logic [15:0] MSC_SPIKE_LIM_RST = 16'h7fff;
  // fixed-point scale of 1.14 factors
  localparam int MSC_FRAC_BITS = 14;
  localparam logic signed [17:0] MSC_S16_MAX = 18'sh0_7fff;
  localparam logic signed [17:0] MSC_S16_MIN = -18'sh0_8000;
endpackage

// ---- msc_core.sv ----
/*
  metering sample correction datapath: spike filter, common-mode rejection,
  offset trims, current scaling, phase trim hold, power gain and offset,
  flag rise notification and interrupt.
  assumes samples, strobe and zero offsets come from logic on clk.
*/
// Behaviour
// - control bit 8 enables the voltage spike filter, otherwise samples pass unchecked.
// - with the filter on, a sample whose jump from the last one is below the limit is kept.
// - with the filter on, a jump at or above the limit replaces the sample by an estimate from the two before.
// - control bit 9 enables common-mode rejection on current two, active only with a compensation above zero.
// - a message goes to the host only when a flag rises from clear to set and its enable bit is set.
// - no message for a steady flag, a cleared flag, or a flag set again while already set.
// - flags update whatever the message enables say; the enables only gate messages.
// - each current channel holds a signed 16-bit phase trim, positive meaning current leads.
// - phase correction runs only when the channel's phase trim is non-zero; the code applies none, it only raises phase1_active/phase2_active then.
// - corrected voltage is raw minus zero offset plus the voltage offset trim.
// - the zero offset is the startup shorted-input value without dc strip, else the dc strip value.
// - with dc strip on, the channel's offset trim is ignored.
// - corrected current is raw minus zero offset plus trim, times the 1.14 scale factor, over 2^14.
// - each product is corrected by the channel's 1.14 gain trim and power offset; each channel's power is output on its own.
// - power is current times voltage times gain over 2^14 plus the signed 32-bit power offset.
`timescale 1ns/10ps
module msc_core #(
  parameter int SW = 16,
  parameter int FW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register port
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // raw converter samples
  input wire logic sample_stb,
  input wire logic signed [SW-1:0] v_raw,
  input wire logic signed [SW-1:0] i1_raw,
  input wire logic signed [SW-1:0] i2_raw,
  // zero offsets: startup shorted-input and dc strip results
  input wire logic signed [SW-1:0] v_zero_init,
  input wire logic signed [SW-1:0] i1_zero_init,
  input wire logic signed [SW-1:0] i2_zero_init,
  input wire logic signed [SW-1:0] v_zero_dc,
  input wire logic signed [SW-1:0] i1_zero_dc,
  input wire logic signed [SW-1:0] i2_zero_dc,
  // processor flags
  input wire logic [FW-1:0] flag_set,
  input wire logic [FW-1:0] flag_clr,
  // corrected outputs
  output logic out_valid,
  output logic signed [SW-1:0] voltage_sample_corrected,
  output logic signed [SW-1:0] current1_sample_corrected,
  output logic signed [SW-1:0] current2_sample_corrected,
  output logic signed [31:0] power1,
  output logic signed [31:0] power2,
  output logic phase1_active,
  output logic phase2_active,
  output logic signed [15:0] phase_trim1,
  output logic signed [15:0] phase_trim2,
  output logic cm_rejection_active,
  // host notification and interrupt
  output logic notify_message,
  output logic [FW-1:0] notify_flags,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [15:0] ctrl_r, ctrl_nxt;
  logic [15:0] spike_limit_r, spike_limit_nxt;
  logic [15:0] cm_rejection_comp_r, cm_rejection_comp_nxt;
  logic [15:0] voltage_offset_trim_r, voltage_offset_trim_nxt;
  logic [15:0] cur_ofs_r [2], cur_ofs_nxt [2];
  logic [15:0] scale_r [2], scale_nxt [2];
  logic [15:0] gain_r [2], gain_nxt [2];
  logic [15:0] phase_r [2], phase_nxt [2];
  logic [31:0] poff_r [2], poff_nxt [2];
  logic [FW-1:0] processor_flag_word_r, processor_flag_word_nxt;
  logic [FW-1:0] msg_en_r, msg_en_nxt;
  logic [2:0] irq_stat_r, irq_stat_nxt;
  logic [2:0] irq_mask_r, irq_mask_nxt;
  logic [15:0] reg_rdata_nxt;
  logic wr_hit [32];

  // datapath state
  logic signed [SW-1:0] v_prev1_r, v_prev1_nxt, v_prev2_r, v_prev2_nxt;
  logic [1:0] hist_r, hist_nxt;
  logic signed [SW-1:0] v_out_r, v_out_nxt, i1_out_r, i1_out_nxt, i2_out_r, i2_out_nxt;
  logic signed [31:0] p1_r, p1_nxt, p2_r, p2_nxt;
  logic valid_r, valid_nxt;
  logic notify_r, notify_nxt;
  logic [FW-1:0] notify_flags_r, notify_flags_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // arithmetic helpers
  function automatic logic signed [SW-1:0] sat16(input logic signed [SW+1:0] x);
    logic signed [SW-1:0] r;
    r = x[SW-1:0];
    if (x > SW'(msc_pkg::MSC_S16_MAX)) begin
      r = msc_pkg::MSC_S16_MAX[SW-1:0];
    end else if (x < msc_pkg::MSC_S16_MIN) begin
      r = msc_pkg::MSC_S16_MIN[SW-1:0];
    end
    return r;
  endfunction

  // raw - zero + trim, trim dropped under dc strip
  function automatic logic signed [SW-1:0] offs(input logic signed [SW-1:0] raw,
    input logic signed [SW-1:0] zi, input logic signed [SW-1:0] zd,
    input logic dc, input logic signed [15:0] trim);
    logic signed [SW+1:0] s;
    s = (SW+2)'(raw) - (SW+2)'(dc ? zd : zi);
    if (!dc) begin
      s = s + (SW+2)'(trim);
    end
    return sat16(s);
  endfunction

  function automatic logic signed [SW-1:0] scale14(input logic signed [SW-1:0] x, input logic [15:0] f);
    logic signed [SW+17:0] m;
    m = (SW+18)'(x) * $signed({2'b00, f});
    m = m >>> msc_pkg::MSC_FRAC_BITS;
    return sat16(m[SW+1:0]);
  endfunction

  function automatic logic signed [31:0] power(input logic signed [SW-1:0] i, input logic signed [SW-1:0] v,
    input logic [15:0] g, input logic [31:0] po);
    logic signed [63:0] m;
    m = 64'(i) * 64'(v);
    m = m * $signed({48'h0000_0000_0000, g});
    m = m >>> msc_pkg::MSC_FRAC_BITS;
    return m[31:0] + $signed(po);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    ctrl_nxt = ctrl_r;
    spike_limit_nxt = spike_limit_r;
    cm_rejection_comp_nxt = cm_rejection_comp_r;
    voltage_offset_trim_nxt = voltage_offset_trim_r;
    msg_en_nxt = msg_en_r;
    irq_mask_nxt = irq_mask_r;
    for (int k = 0; k < 32; k++) begin
      wr_hit[k] = reg_wr && (reg_addr == 5'(k));
    end
    for (int c = 0; c < 2; c++) begin
      cur_ofs_nxt[c] = cur_ofs_r[c];
      scale_nxt[c] = scale_r[c];
      gain_nxt[c] = gain_r[c];
      phase_nxt[c] = phase_r[c];
      poff_nxt[c] = poff_r[c];
      if (wr_hit[msc_pkg::MSC_I1_OFS_OFS + 5'(c)]) cur_ofs_nxt[c] = reg_wdata;
      if (wr_hit[msc_pkg::MSC_I1_SCALE_OFS + 5'(c)]) scale_nxt[c] = reg_wdata;
      if (wr_hit[msc_pkg::MSC_I1_GAIN_OFS + 5'(c)]) gain_nxt[c] = reg_wdata;
      if (wr_hit[msc_pkg::MSC_I1_PHASE_OFS + 5'(c)]) phase_nxt[c] = reg_wdata;
      if (wr_hit[msc_pkg::MSC_P1_OFS_LO_OFS + 5'(2 * c)]) poff_nxt[c][15:0] = reg_wdata;
      if (wr_hit[msc_pkg::MSC_P1_OFS_HI_OFS + 5'(2 * c)]) poff_nxt[c][31:16] = reg_wdata;
    end
    if (wr_hit[msc_pkg::MSC_CTRL_OFS]) ctrl_nxt = reg_wdata;
    if (wr_hit[msc_pkg::MSC_SPIKE_LIM_OFS]) spike_limit_nxt = reg_wdata;
    if (wr_hit[msc_pkg::MSC_CM_COMP_OFS]) cm_rejection_comp_nxt = reg_wdata;
    if (wr_hit[msc_pkg::MSC_V_OFS_OFS]) voltage_offset_trim_nxt = reg_wdata;
    if (wr_hit[msc_pkg::MSC_MSG_EN_OFS]) msg_en_nxt = reg_wdata[FW-1:0];
    if (wr_hit[msc_pkg::MSC_IRQ_MASK_OFS]) irq_mask_nxt = reg_wdata[2:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags and notification
  always_comb begin
    logic [FW-1:0] rise;
    rise = '0;
    // write of a one sets a flag too; clears lose to sets
    processor_flag_word_nxt = (processor_flag_word_r & ~flag_clr) | flag_set;
    if (wr_hit[msc_pkg::MSC_FLAG_OFS]) begin
      processor_flag_word_nxt = processor_flag_word_nxt | reg_wdata[FW-1:0];
    end
    rise = processor_flag_word_nxt & ~processor_flag_word_r;
    notify_flags_nxt = rise & msg_en_r;
    notify_nxt = |notify_flags_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample datapath
  always_comb begin
    logic signed [SW-1:0] v_corr, v_sel, i1_c, i2_c, i2_cm;
    logic signed [SW+1:0] diff, est;
    logic [SW+1:0] adiff;
    logic spike;
    {v_sel, i1_c, i2_c, i2_cm, diff, est, adiff} = '0;
    spike = 1'b0;
    v_corr = offs(v_raw, v_zero_init, v_zero_dc, ctrl_r[msc_pkg::MSC_V_DC_BIT], voltage_offset_trim_r);
    diff = (SW+2)'(v_corr) - (SW+2)'(v_prev1_r);
    adiff = diff[SW+1] ? (SW+2)'(-diff) : diff;
    // estimate needs two samples of history, so the first two pass as-is
    spike = ctrl_r[msc_pkg::MSC_SPIKE_BIT] && (hist_r == 2'b11)
            && (adiff >= (SW+2)'(spike_limit_r));
    est = ((SW+2)'(v_prev1_r) <<< 1) - (SW+2)'(v_prev2_r);
    v_sel = spike ? sat16(est) : v_corr;
    i1_c = scale14(offs(i1_raw, i1_zero_init, i1_zero_dc, ctrl_r[msc_pkg::MSC_I1_DC_BIT], cur_ofs_r[0]),
                   scale_r[0]);
    i2_c = scale14(offs(i2_raw, i2_zero_init, i2_zero_dc, ctrl_r[msc_pkg::MSC_I2_DC_BIT], cur_ofs_r[1]),
                   scale_r[1]);
    // common-mode share of voltage removed, weighted by the compensation
    i2_cm = sat16((SW+2)'(i2_c) - (SW+2)'(scale14(v_sel, cm_rejection_comp_r)));
    if (cm_rejection_active) begin
      i2_c = i2_cm;
    end
    v_prev1_nxt = v_prev1_r;
    v_prev2_nxt = v_prev2_r;
    hist_nxt = hist_r;
    v_out_nxt = v_out_r;
    i1_out_nxt = i1_out_r;
    i2_out_nxt = i2_out_r;
    p1_nxt = p1_r;
    p2_nxt = p2_r;
    valid_nxt = sample_stb;
    irq_stat_nxt = irq_stat_r;
    if (wr_hit[msc_pkg::MSC_IRQ_STAT_OFS]) begin
      irq_stat_nxt = irq_stat_nxt & ~reg_wdata[2:0];
    end
    if (notify_nxt) irq_stat_nxt[msc_pkg::MSC_IRQ_MSG_BIT] = 1'b1;
    if (sample_stb) begin
      v_prev2_nxt = v_prev1_r;
      v_prev1_nxt = v_sel;
      hist_nxt = {hist_r[0], 1'b1};
      v_out_nxt = v_sel;
      i1_out_nxt = i1_c;
      i2_out_nxt = i2_c;
      p1_nxt = power(i1_c, v_sel, gain_r[0], poff_r[0]);
      p2_nxt = power(i2_c, v_sel, gain_r[1], poff_r[1]);
      irq_stat_nxt[msc_pkg::MSC_IRQ_SAMPLE_BIT] = 1'b1;
      if (spike) irq_stat_nxt[msc_pkg::MSC_IRQ_SPIKE_BIT] = 1'b1;
    end
  end

  assign cm_rejection_active = ctrl_r[msc_pkg::MSC_CMR_BIT] && ($signed(cm_rejection_comp_r) > 0);
  assign phase1_active = (phase_r[0] != 16'h0000);
  assign phase2_active = (phase_r[1] != 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    reg_rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        msc_pkg::MSC_CTRL_OFS: reg_rdata_nxt = ctrl_r;
        msc_pkg::MSC_SPIKE_LIM_OFS: reg_rdata_nxt = spike_limit_r;
        msc_pkg::MSC_CM_COMP_OFS: reg_rdata_nxt = cm_rejection_comp_r;
        msc_pkg::MSC_V_OFS_OFS: reg_rdata_nxt = voltage_offset_trim_r;
        msc_pkg::MSC_I1_OFS_OFS: reg_rdata_nxt = cur_ofs_r[0];
        msc_pkg::MSC_I2_OFS_OFS: reg_rdata_nxt = cur_ofs_r[1];
        msc_pkg::MSC_I1_SCALE_OFS: reg_rdata_nxt = scale_r[0];
        msc_pkg::MSC_I2_SCALE_OFS: reg_rdata_nxt = scale_r[1];
        msc_pkg::MSC_I1_GAIN_OFS: reg_rdata_nxt = gain_r[0];
        msc_pkg::MSC_I2_GAIN_OFS: reg_rdata_nxt = gain_r[1];
        msc_pkg::MSC_I1_PHASE_OFS: reg_rdata_nxt = phase_r[0];
        msc_pkg::MSC_I2_PHASE_OFS: reg_rdata_nxt = phase_r[1];
        msc_pkg::MSC_P1_OFS_LO_OFS: reg_rdata_nxt = poff_r[0][15:0];
        msc_pkg::MSC_P1_OFS_HI_OFS: reg_rdata_nxt = poff_r[0][31:16];
        msc_pkg::MSC_P2_OFS_LO_OFS: reg_rdata_nxt = poff_r[1][15:0];
        msc_pkg::MSC_P2_OFS_HI_OFS: reg_rdata_nxt = poff_r[1][31:16];
        msc_pkg::MSC_FLAG_OFS: reg_rdata_nxt = 16'(processor_flag_word_r);
        msc_pkg::MSC_MSG_EN_OFS: reg_rdata_nxt = 16'(msg_en_r);
        msc_pkg::MSC_IRQ_STAT_OFS: reg_rdata_nxt = {13'h0000, irq_stat_r};
        msc_pkg::MSC_IRQ_MASK_OFS: reg_rdata_nxt = {13'h0000, irq_mask_r};
        msc_pkg::MSC_V_OUT_OFS: reg_rdata_nxt = 16'(v_out_r);
        msc_pkg::MSC_I1_OUT_OFS: reg_rdata_nxt = 16'(i1_out_r);
        msc_pkg::MSC_I2_OUT_OFS: reg_rdata_nxt = 16'(i2_out_r);
        default: reg_rdata_nxt = 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_r <= msc_pkg::MSC_CTRL_RST;
      spike_limit_r <= msc_pkg::MSC_SPIKE_LIM_RST;
      cm_rejection_comp_r <= msc_pkg::MSC_ZERO_RST;
      voltage_offset_trim_r <= msc_pkg::MSC_ZERO_RST;
      for (int c = 0; c < 2; c++) begin
        cur_ofs_r[c] <= msc_pkg::MSC_ZERO_RST;
        scale_r[c] <= msc_pkg::MSC_UNITY_RST;
        gain_r[c] <= msc_pkg::MSC_UNITY_RST;
        phase_r[c] <= msc_pkg::MSC_ZERO_RST;
        poff_r[c] <= 32'h0000_0000;
      end
      processor_flag_word_r <= '0;
      msg_en_r <= '0;
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
      reg_rdata <= 16'h0000;
      v_prev1_r <= '0;
      v_prev2_r <= '0;
      hist_r <= 2'b00;
      v_out_r <= '0;
      i1_out_r <= '0;
      i2_out_r <= '0;
      p1_r <= 32'sh0000_0000;
      p2_r <= 32'sh0000_0000;
      valid_r <= 1'b0;
      notify_r <= 1'b0;
      notify_flags_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      spike_limit_r <= spike_limit_nxt;
      cm_rejection_comp_r <= cm_rejection_comp_nxt;
      voltage_offset_trim_r <= voltage_offset_trim_nxt;
      for (int c = 0; c < 2; c++) begin
        cur_ofs_r[c] <= cur_ofs_nxt[c];
        scale_r[c] <= scale_nxt[c];
        gain_r[c] <= gain_nxt[c];
        phase_r[c] <= phase_nxt[c];
        poff_r[c] <= poff_nxt[c];
      end
      processor_flag_word_r <= processor_flag_word_nxt;
      msg_en_r <= msg_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      reg_rdata <= reg_rdata_nxt;
      v_prev1_r <= v_prev1_nxt;
      v_prev2_r <= v_prev2_nxt;
      hist_r <= hist_nxt;
      v_out_r <= v_out_nxt;
      i1_out_r <= i1_out_nxt;
      i2_out_r <= i2_out_nxt;
      p1_r <= p1_nxt;
      p2_r <= p2_nxt;
      valid_r <= valid_nxt;
      notify_r <= notify_nxt;
      notify_flags_r <= notify_flags_nxt;
    end
  end

  assign out_valid = valid_r;
  assign voltage_sample_corrected = v_out_r;
  assign current1_sample_corrected = i1_out_r;
  assign current2_sample_corrected = i2_out_r;
  assign power1 = p1_r;
  assign power2 = p2_r;
  assign phase_trim1 = phase_r[0];
  assign phase_trim2 = phase_r[1];
  assign notify_message = notify_r;
  assign notify_flags = notify_flags_r;
  assign irq = |(irq_stat_r & irq_mask_r);

endmodule

// ---- msc_core_assertions.sv ----
/*
  port-level checker for msc_core, bound into every instance.
  assumes one clock domain, clk rising, rst_b async active low.
*/
`timescale 1ns/10ps
module msc_core_chk #(
  parameter int SW = 16,
  parameter int FW = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // watched ports
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic sample_stb,
  input wire logic [FW-1:0] flag_set,
  input wire logic out_valid,
  input wire logic signed [SW-1:0] voltage_sample_corrected,
  input wire logic phase1_active,
  input wire logic phase2_active,
  input wire logic signed [15:0] phase_trim1,
  input wire logic signed [15:0] phase_trim2,
  input wire logic notify_message,
  input wire logic [FW-1:0] notify_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  valid_after_stb_a: assert property (sample_stb |=> out_valid)
    else $error("no out_valid after sample strobe");
  valid_only_a: assert property (!sample_stb |=> !out_valid)
    else $error("out_valid without sample strobe");
  volt_hold_a: assert property (!sample_stb |=> $stable(voltage_sample_corrected))
    else $error("voltage changed between samples");
  notify_flags_a: assert property (notify_message |-> notify_flags != '0)
    else $error("message with no flag named");
  // without a rising cause no message may follow
  no_rise_a: assert property ((flag_set == '0 && !(reg_wr && reg_addr == msc_pkg::MSC_FLAG_OFS))
    |=> !notify_message)
    else $error("message without a flag rise");
  phase1_act_a: assert property (phase1_active == (phase_trim1 != 16'sh0000))
    else $error("phase one active mismatch");
  phase2_act_a: assert property (phase2_active == (phase_trim2 != 16'sh0000))
    else $error("phase two active mismatch");
  trim_hold_a: assert property (!reg_wr |=> $stable(phase_trim1) && $stable(phase_trim2))
    else $error("phase trim moved without a write");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind msc_core msc_core_chk #(.SW(SW), .FW(FW)) u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .sample_stb(sample_stb), .flag_set(flag_set), .out_valid(out_valid),
  .voltage_sample_corrected(voltage_sample_corrected), .phase1_active(phase1_active),
  .phase2_active(phase2_active), .phase_trim1(phase_trim1), .phase_trim2(phase_trim2),
  .notify_message(notify_message), .notify_flags(notify_flags));

// ---- msc_host_adc.sv ----
/*
  converter and host mailbox model facing msc_core.
  assumes convert is called just after a rising clk edge.
*/
`timescale 1ns/10ps
module msc_host_adc (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // converter side
  output logic sample_stb,
  output logic signed [15:0] v_raw,
  output logic signed [15:0] i1_raw,
  output logic signed [15:0] i2_raw,
  // mailbox side
  input wire logic notify_message,
  input wire logic [15:0] notify_flags,
  output logic [7:0] msg_count,
  output logic [15:0] msg_flags
);
  initial begin
    sample_stb = 1'b0;
    v_raw = 16'sh0000;
    i1_raw = 16'sh0000;
    i2_raw = 16'sh0000;
  end
  // results go stale after the strobe, so lines show the inverse
  task automatic convert(input logic signed [15:0] v, i1, i2);
    sample_stb <= 1'b1;
    v_raw <= v;
    i1_raw <= i1;
    i2_raw <= i2;
    @(posedge clk);
    sample_stb <= 1'b0;
    v_raw <= ~v;
    i1_raw <= ~i1;
    i2_raw <= ~i2;
    @(posedge clk);
  endtask
  // mailbox counts every one-cycle message
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msg_count <= 8'h00;
      msg_flags <= 16'h0000;
    end else if (notify_message) begin
      msg_count <= msg_count + 8'h01;
      msg_flags <= notify_flags;
    end
  end
endmodule

// ---- metering_sample_correction_test.sv ----
/*
  self-checking bench for msc_core through its register port.
  assumes the converter/mailbox model and the bound checker.
*/
`timescale 1ns/10ps
module metering_sample_correction_test;
  logic clk, rst_b, reg_wr, reg_rd, sample_stb, out_valid, notify_message, ph1, ph2, cm_act, irq;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, flag_set, flag_clr, notify_flags, msg_flags;
  logic signed [15:0] v_raw, i1_raw, i2_raw, vz_i, i1z_i, i2z_i, vz_d, i1z_d, i2z_d;
  logic signed [15:0] v_c, i1_c, i2_c, pt1, pt2;
  logic signed [31:0] p1, p2;
  logic [7:0] msg_count;
  int miscompares, compares, cycles;
  msc_core u_dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_stb(sample_stb), .v_raw(v_raw), .i1_raw(i1_raw),
    .i2_raw(i2_raw), .v_zero_init(vz_i), .i1_zero_init(i1z_i), .i2_zero_init(i2z_i), .v_zero_dc(vz_d),
    .i1_zero_dc(i1z_d), .i2_zero_dc(i2z_d), .flag_set(flag_set), .flag_clr(flag_clr),
    .out_valid(out_valid), .voltage_sample_corrected(v_c), .current1_sample_corrected(i1_c),
    .current2_sample_corrected(i2_c), .power1(p1), .power2(p2), .phase1_active(ph1), .phase2_active(ph2),
    .phase_trim1(pt1), .phase_trim2(pt2), .cm_rejection_active(cm_act), .notify_message(notify_message),
    .notify_flags(notify_flags), .irq(irq));
  msc_host_adc u_adc (.clk(clk), .rst_b(rst_b), .sample_stb(sample_stb), .v_raw(v_raw), .i1_raw(i1_raw),
    .i2_raw(i2_raw), .notify_message(notify_message), .notify_flags(notify_flags),
    .msg_count(msg_count), .msg_flags(msg_flags));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk32(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  // masked read compare; data stands only in the cycle after the strobe
  task automatic rdc(input logic [4:0] a, input logic [15:0] m, exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk16(reg_rdata & m, exp);
    @(posedge clk);
  endtask
  task automatic vs(input logic [15:0] raw, exp);
    u_adc.convert(raw, 16'h0000, 16'h0000);
    chk16(v_c, exp);
  endtask
  task automatic fl(input logic [15:0] s, c, input int n);
    flag_set <= s;
    flag_clr <= c;
    repeat (n) @(posedge clk);
    flag_set <= 16'h0000;
    flag_clr <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, far above the roughly 120 cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata, flag_set, flag_clr} = '0;
    {vz_i, i1z_i, i2z_i, vz_d, i1z_d, i2z_d} = '0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    rdc(msc_pkg::MSC_CTRL_OFS, 16'hffff, 16'h0000);
    rdc(msc_pkg::MSC_SPIKE_LIM_OFS, 16'hffff, 16'h7fff);
    rdc(msc_pkg::MSC_I1_SCALE_OFS, 16'hffff, 16'h4000);
    rdc(msc_pkg::MSC_I2_SCALE_OFS, 16'hffff, 16'h4000);
    rdc(msc_pkg::MSC_I1_GAIN_OFS, 16'hffff, 16'h4000);
    rdc(msc_pkg::MSC_I2_GAIN_OFS, 16'hffff, 16'h4000);
    rdc(msc_pkg::MSC_I2_PHASE_OFS, 16'hffff, 16'h0000);
    rdc(msc_pkg::MSC_V_OFS_OFS, 16'hffff, 16'h0000);
    wr(5'h1f, 16'hffff);
    rdc(5'h1f, 16'hffff, 16'h0000);
    // offsets, scaling and power
    vz_i <= 16'sh000a;
    vz_d <= 16'sh0014;
    i2z_d <= 16'sh001e;
    i1z_d <= 16'sh0064;
    wr(msc_pkg::MSC_V_OFS_OFS, 16'h0005);
    vs(16'h0064, 16'h005f);
    wr(msc_pkg::MSC_CTRL_OFS, 16'h00e0);
    vs(16'h0064, 16'h0050);
    wr(msc_pkg::MSC_I2_OFS_OFS, 16'h0009);
    wr(msc_pkg::MSC_I1_SCALE_OFS, 16'h6000);
    wr(msc_pkg::MSC_I1_GAIN_OFS, 16'h2000);
    wr(msc_pkg::MSC_P1_OFS_LO_OFS, 16'h0007);
    u_adc.convert(16'h0064, 16'h03e8, 16'h0082);
    chk16(i1_c, 16'h0546);
    chk16(i2_c, 16'h0064);
    chk32(p1, 32'h0000_d2f7);
    chk32(p2, 32'h0000_1f40);
    // spike filter, boundary jump and saturation
    vz_i <= 16'sh0000;
    wr(msc_pkg::MSC_V_OFS_OFS, 16'h0000);
    wr(msc_pkg::MSC_CTRL_OFS, 16'h0100);
    vs(16'h000a, 16'h000a);
    vs(16'h0014, 16'h0014);
    wr(msc_pkg::MSC_SPIKE_LIM_OFS, 16'h0032);
    vs(16'h0046, 16'h001e);
    rdc(msc_pkg::MSC_IRQ_STAT_OFS, 16'h0002, 16'h0002);
    vs(16'h0028, 16'h0028);
    wr(msc_pkg::MSC_SPIKE_LIM_OFS, 16'h7fff);
    vs(16'h0000, 16'h0000);
    vs(16'h7d00, 16'h7d00);
    wr(msc_pkg::MSC_SPIKE_LIM_OFS, 16'h0032);
    vs(16'h0000, 16'h7fff);
    wr(msc_pkg::MSC_CTRL_OFS, 16'h0000);
    vs(16'h0000, 16'h0000);
    // common-mode enable needs a positive compensation
    wr(msc_pkg::MSC_CTRL_OFS, 16'h0200);
    chk16({15'h0000, cm_act}, 16'h0000);
    wr(msc_pkg::MSC_CM_COMP_OFS, 16'h0001);
    chk16({15'h0000, cm_act}, 16'h0001);
    wr(msc_pkg::MSC_CM_COMP_OFS, 16'h8000);
    chk16({15'h0000, cm_act}, 16'h0000);
    // unity compensation removes the whole voltage from current two
    wr(msc_pkg::MSC_CM_COMP_OFS, 16'h4000);
    u_adc.convert(16'h0064, 16'h0000, 16'h012c);
    chk16(i2_c, 16'h00d1);
    chk32(p2, 32'h0000_51a4);
    // phase trims
    wr(msc_pkg::MSC_I1_PHASE_OFS, 16'hffc6);
    chk16(pt1, 16'hffc6);
    chk16({15'h0000, ph1}, 16'h0001);
    wr(msc_pkg::MSC_I1_PHASE_OFS, 16'h0000);
    chk16({15'h0000, ph1}, 16'h0000);
    wr(msc_pkg::MSC_I2_PHASE_OFS, 16'h005f);
    chk16(pt2, 16'h005f);
    chk16({15'h0000, ph2}, 16'h0001);
    // flag rises, messages and interrupt
    wr(msc_pkg::MSC_MSG_EN_OFS, 16'h0008);
    wr(msc_pkg::MSC_IRQ_MASK_OFS, 16'h0004);
    fl(16'h0008, 16'h0000, 1);
    chk16({8'h00, msg_count}, 16'h0001);
    chk16(msg_flags, 16'h0008);
    chk16({15'h0000, irq}, 16'h0001);
    fl(16'h0008, 16'h0000, 3);
    fl(16'h0004, 16'h0000, 1);
    wr(msc_pkg::MSC_FLAG_OFS, 16'h0008);
    fl(16'h0000, 16'h0008, 1);
    chk16({8'h00, msg_count}, 16'h0001);
    rdc(msc_pkg::MSC_FLAG_OFS, 16'h000c, 16'h0004);
    wr(msc_pkg::MSC_IRQ_STAT_OFS, 16'h0007);
    chk16({15'h0000, irq}, 16'h0000);
    wr(msc_pkg::MSC_FLAG_OFS, 16'h0008);
    repeat (2) @(posedge clk);
    chk16({8'h00, msg_count}, 16'h0002);
    results();
  end
endmodule
